// file: hdl/ride_through_pkg.sv
// Shared constants and types for the supply dip ride-through ends
package ride_through_pkg;
  // 1 ms timebase from the 100 MHz core clock
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * CLK_FREQ_KHZ;

  localparam int MS_W = 10;
  localparam int PCT_W = 7;
  localparam int PRM_W = 16;

  localparam logic [MS_W-1:0] HOLD_MIN = 10'h014;
  localparam logic [MS_W-1:0] HOLD_MAX = 10'h3E8;
  localparam logic [MS_W-1:0] HOLD_RST = 10'h014;
  localparam logic [MS_W-1:0] RELEASE_MIN = 10'h000;
  localparam logic [MS_W-1:0] RELEASE_MAX = 10'h3E8;
  localparam logic [MS_W-1:0] RELEASE_RST = 10'h064;
  localparam logic [MS_W-1:0] LIMIT_MIN = 10'h000;
  localparam logic [MS_W-1:0] LIMIT_MAX = 10'h064;
  localparam logic [PCT_W-1:0] LIMIT_RST = 7'h32;
  localparam logic [PCT_W-1:0] TORQUE_FULL = 7'h64;

  typedef enum logic [1:0] {
    UV_OFF = 2'h0,
    UV_HOST = 2'h1,
    UV_INTERNAL = 2'h2
  } uv_mode_t;

  // Parameter select codes on the link
  localparam logic [1:0] PRM_HOLD = 2'h0;
  localparam logic [1:0] PRM_MODE = 2'h1;
  localparam logic [1:0] PRM_LIMIT = 2'h2;
  localparam logic [1:0] PRM_RELEASE = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_DIP = 4'h4,
    ST_CUT = 4'h8
  } dip_state_t;

  typedef enum logic [2:0] {
    LIM_FREE = 3'h1,
    LIM_HOLD = 3'h2,
    LIM_RELEASE = 3'h4
  } lim_state_t;

  // Host register map, byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  localparam logic [7:0] OFS_HOLD = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_LIMIT = 8'h18;
  localparam logic [7:0] OFS_RELEASE = 8'h1C;

  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_OFF_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;

  localparam int INT_W = 3;
  localparam int EV_WARN_SET = 0;
  localparam int EV_WARN_CLR = 1;
  localparam int EV_READY_LOST = 2;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;
endpackage

// file: hdl/ride_through_if.sv
// Command link between host motion controller and drive supervisor
`timescale 1ns/1ps
`default_nettype none
interface ride_through_if;
  logic servo_on_cmd;
  logic servo_off_cmd;
  logic restart_cmd;
  logic prm_wr;
  logic [1:0] prm_sel;
  logic [15:0] prm_data;
  logic servo_ready;
  logic uv_warning;
  logic motor_powered;

  modport dev (
    input servo_on_cmd,
    input servo_off_cmd,
    input restart_cmd,
    input prm_wr,
    input prm_sel,
    input prm_data,
    output servo_ready,
    output uv_warning,
    output motor_powered
  );

  modport host (
    output servo_on_cmd,
    output servo_off_cmd,
    output restart_cmd,
    output prm_wr,
    output prm_sel,
    output prm_data,
    input servo_ready,
    input uv_warning,
    input motor_powered
  );
endinterface
`default_nettype wire

// file: hdl/ride_through_dev.sv
// Drive-side supply dip supervisor with undervoltage torque limiter
// Overview of operation
// - Keep motor powered within hold time, else cut
// - Re-energise motor when main supply returns
// - Drop servo ready when hold time exceeded
// - Control supply loss acts as plain power-down
// - Undervoltage alarm during dip ignores hold time
// - Mode digit selects undervoltage handling after restart
// - Host limits torque when warning appears
// - Host lifts limit only after warning clears
// - Internal mode clamps torque on warning
// - Internal mode releases limit over release time
// - Limit held as percent of rated torque
// - Integrator should program hold time 1000 ms
// - Servo-off command stops motor current at once
`timescale 1ns/1ps
`default_nettype none
module ride_through_dev #(
  parameter int TICK_CYCLES = ride_through_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  ride_through_if.dev link,
  input wire logic main_supply_ok,
  input wire logic ctrl_supply_ok,
  input wire logic dc_bus_low,
  input wire logic uv_alarm,
  output logic motor_power_on,
  output logic servo_ready,
  output logic torque_limit_active,
  output logic [ride_through_pkg::PCT_W-1:0] torque_limit_pct
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  function automatic logic [ride_through_pkg::MS_W-1:0] clamp_ms(
    input logic [ride_through_pkg::PRM_W-1:0] v,
    input logic [ride_through_pkg::MS_W-1:0] lo,
    input logic [ride_through_pkg::MS_W-1:0] hi
  );
    logic [ride_through_pkg::MS_W-1:0] r;
    r = v[ride_through_pkg::MS_W-1:0];
    if (v < {6'h00, lo}) begin
      r = lo;
    end else if (v > {6'h00, hi}) begin
      r = hi;
    end
    return r;
  endfunction

  // Sensor inputs are asynchronous: three stages, accept when 2nd and 3rd agree
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;
  logic [3:0] filt_r;
  wire [3:0] raw_in = {uv_alarm, dc_bus_low, ctrl_supply_ok, main_supply_ok};
  wire [3:0] filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
  wire main_ok = filt_r[0];
  wire ctrl_ok = filt_r[1];
  wire dc_low = filt_r[2];
  wire uv_alarm_f = filt_r[3];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
      filt_r <= 4'h0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
    end
  end

  // Settings, all applied at once except the mode
  logic [ride_through_pkg::MS_W-1:0] hold_r;
  logic [ride_through_pkg::MS_W-1:0] release_r;
  logic [ride_through_pkg::PCT_W-1:0] limit_r;
  logic [1:0] mode_pend_r;
  logic [1:0] mode_act_r;
  wire [ride_through_pkg::MS_W-1:0] hold_wr =
    clamp_ms(link.prm_data, ride_through_pkg::HOLD_MIN, ride_through_pkg::HOLD_MAX);
  wire [ride_through_pkg::MS_W-1:0] release_wr =
    clamp_ms(link.prm_data, ride_through_pkg::RELEASE_MIN, ride_through_pkg::RELEASE_MAX);
  wire [ride_through_pkg::MS_W-1:0] limit_wr =
    clamp_ms(link.prm_data, ride_through_pkg::LIMIT_MIN, ride_through_pkg::LIMIT_MAX);
  wire mode_legal = link.prm_data <= 16'(ride_through_pkg::UV_INTERNAL);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= ride_through_pkg::HOLD_RST;
      release_r <= ride_through_pkg::RELEASE_RST;
      limit_r <= ride_through_pkg::LIMIT_RST;
      mode_pend_r <= ride_through_pkg::UV_OFF;
      mode_act_r <= ride_through_pkg::UV_OFF;
    end else begin
      if (link.prm_wr && link.prm_sel == ride_through_pkg::PRM_HOLD) begin
        hold_r <= hold_wr;
      end
      if (link.prm_wr && link.prm_sel == ride_through_pkg::PRM_RELEASE) begin
        release_r <= release_wr;
      end
      if (link.prm_wr && link.prm_sel == ride_through_pkg::PRM_LIMIT) begin
        limit_r <= limit_wr[ride_through_pkg::PCT_W-1:0];
      end
      if (link.prm_wr && link.prm_sel == ride_through_pkg::PRM_MODE && mode_legal) begin
        mode_pend_r <= link.prm_data[1:0];
      end
      // mode only takes effect on restart
      if (link.restart_cmd) begin
        mode_act_r <= mode_pend_r;
      end
    end
  end

  // one 1 ms prescaler per timer so each restarts cleanly
  logic [1:0] tick;
  logic [1:0] tick_restart;
  genvar g;
  for (g = 0; g < 2; g++) begin : g_tick
    logic [DIV_W-1:0] div_r;
    assign tick[g] = div_r == DIV_LAST;
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        div_r <= '0;
      end else if (tick_restart[g] || tick[g]) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // Dip supervisor
  ride_through_pkg::dip_state_t state_r;
  ride_through_pkg::dip_state_t state_nxt;
  logic [ride_through_pkg::MS_W-1:0] hold_cnt_r;
  logic [ride_through_pkg::MS_W-1:0] hold_cnt_nxt;
  wire dip_start = state_r == ride_through_pkg::ST_RUN && !main_ok;
  wire hold_over = hold_cnt_r >= hold_r;

  always_comb begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    if (!ctrl_ok || link.servo_off_cmd) begin
      state_nxt = ride_through_pkg::ST_IDLE;
    end else begin
      case (state_r)
        ride_through_pkg::ST_IDLE: begin
          if (link.servo_on_cmd && main_ok) begin
            state_nxt = ride_through_pkg::ST_RUN;
          end
        end
        ride_through_pkg::ST_RUN: begin
          if (!main_ok) begin
            state_nxt = ride_through_pkg::ST_DIP;
            hold_cnt_nxt = '0;
          end
        end
        ride_through_pkg::ST_DIP: begin
          if (main_ok) begin
            state_nxt = ride_through_pkg::ST_RUN;
          end else if (uv_alarm_f) begin
            state_nxt = ride_through_pkg::ST_CUT;
          end else if (tick[0]) begin
            if (hold_over) begin
              state_nxt = ride_through_pkg::ST_CUT;
            end else begin
              hold_cnt_nxt = hold_cnt_r + 1'b1;
            end
          end
        end
        ride_through_pkg::ST_CUT: begin
          if (main_ok) begin
            state_nxt = ride_through_pkg::ST_RUN;
          end
        end
        default: state_nxt = ride_through_pkg::ST_IDLE;
      endcase
    end
  end

  assign tick_restart[0] = dip_start;

  wire powered_nxt = state_nxt == ride_through_pkg::ST_RUN ||
    state_nxt == ride_through_pkg::ST_DIP;
  // in a dip ready lost at cut (hold expired or undervoltage alarm), or on control supply loss; servo off keeps ready set while main supply is ok
  wire ready_nxt = ctrl_ok && !uv_alarm_f && state_nxt != ride_through_pkg::ST_CUT &&
    (main_ok || state_nxt == ride_through_pkg::ST_DIP);

  // Undervoltage warning and internal torque limiter
  ride_through_pkg::lim_state_t lim_r;
  ride_through_pkg::lim_state_t lim_nxt;
  logic [ride_through_pkg::MS_W-1:0] rel_cnt_r;
  logic [ride_through_pkg::MS_W-1:0] rel_cnt_nxt;
  logic uv_warning_r;
  wire [ride_through_pkg::MS_W-1:0] rel_cnt_inc = rel_cnt_r + 1'b1;
  wire warn_nxt = dc_low && mode_act_r != ride_through_pkg::UV_OFF;

  always_comb begin
    lim_nxt = lim_r;
    rel_cnt_nxt = rel_cnt_r;
    if (mode_act_r != ride_through_pkg::UV_INTERNAL) begin
      lim_nxt = ride_through_pkg::LIM_FREE;
    end else begin
      case (lim_r)
        ride_through_pkg::LIM_FREE: begin
          if (uv_warning_r) begin
            lim_nxt = ride_through_pkg::LIM_HOLD;
          end
        end
        ride_through_pkg::LIM_HOLD: begin
          if (!uv_warning_r) begin
            rel_cnt_nxt = '0;
            lim_nxt = (release_r == '0) ? ride_through_pkg::LIM_FREE :
              ride_through_pkg::LIM_RELEASE;
          end
        end
        ride_through_pkg::LIM_RELEASE: begin
          if (uv_warning_r) begin
            lim_nxt = ride_through_pkg::LIM_HOLD;
          end else if (tick[1]) begin
            if (rel_cnt_inc >= release_r) begin
              lim_nxt = ride_through_pkg::LIM_FREE;
            end else begin
              rel_cnt_nxt = rel_cnt_inc;
            end
          end
        end
        default: lim_nxt = ride_through_pkg::LIM_FREE;
      endcase
    end
  end

  assign tick_restart[1] = lim_r == ride_through_pkg::LIM_HOLD && !uv_warning_r;

  wire limiting_nxt = lim_nxt != ride_through_pkg::LIM_FREE;
  // Limit read live so a new setting bites immediately
  wire [ride_through_pkg::PCT_W-1:0] pct_nxt = limiting_nxt ? limit_r :
    ride_through_pkg::TORQUE_FULL;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ride_through_pkg::ST_IDLE;
      hold_cnt_r <= '0;
      lim_r <= ride_through_pkg::LIM_FREE;
      rel_cnt_r <= '0;
      uv_warning_r <= 1'b0;
      motor_power_on <= 1'b0;
      servo_ready <= 1'b0;
      torque_limit_active <= 1'b0;
      torque_limit_pct <= ride_through_pkg::TORQUE_FULL;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      lim_r <= lim_nxt;
      rel_cnt_r <= rel_cnt_nxt;
      uv_warning_r <= warn_nxt;
      motor_power_on <= powered_nxt;
      servo_ready <= ready_nxt;
      torque_limit_active <= limiting_nxt;
      torque_limit_pct <= pct_nxt;
    end
  end

  assign link.servo_ready = servo_ready;
  assign link.uv_warning = uv_warning_r;
  assign link.motor_powered = motor_power_on;
endmodule
`default_nettype wire

// file: hdl/ride_through_host.sv
// Host-side controller end: APB registers, link commands, host torque limit
`timescale 1ns/1ps
`default_nettype none
module ride_through_host (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic host_torque_limit,
  ride_through_if.host link
);
  localparam int IW = ride_through_pkg::INT_W;

  logic on_r;
  logic off_r;
  logic restart_r;
  logic prm_wr_r;
  logic [1:0] prm_sel_r;
  logic [15:0] prm_data_r;
  logic [15:0] hold_sh_r;
  logic [15:0] mode_sh_r;
  logic [15:0] limit_sh_r;
  logic [15:0] release_sh_r;
  logic [1:0] mode_act_r;
  logic [IW-1:0] int_stat_r;
  logic [IW-1:0] int_mask_r;
  logic warn_d_r;
  logic ready_d_r;

  // One wait state: pready rises in the second access cycle
  wire access = psel && penable;
  wire first_acc = access && !pready;
  wire wr_done = access && pready && pwrite;
  wire sel_ctrl = paddr == ride_through_pkg::OFS_CTRL;
  wire sel_stat = paddr == ride_through_pkg::OFS_INT_STAT;
  wire sel_mask = paddr == ride_through_pkg::OFS_INT_MASK;
  wire sel_hold = paddr == ride_through_pkg::OFS_HOLD;
  wire sel_mode = paddr == ride_through_pkg::OFS_MODE;
  wire sel_limit = paddr == ride_through_pkg::OFS_LIMIT;
  wire sel_release = paddr == ride_through_pkg::OFS_RELEASE;
  wire sel_status = paddr == ride_through_pkg::OFS_STATUS;
  wire mapped = sel_ctrl | sel_stat | sel_mask | sel_hold | sel_mode | sel_limit |
    sel_release | sel_status;
  wire [31:0] status_word = {28'h0000000, host_torque_limit, link.motor_powered,
    link.uv_warning, link.servo_ready};
  wire [31:0] rd_mux =
    sel_status ? status_word :
    sel_stat ? {29'h00000000, int_stat_r} :
    sel_mask ? {29'h00000000, int_mask_r} :
    sel_hold ? {16'h0000, hold_sh_r} :
    sel_mode ? {16'h0000, mode_sh_r} :
    sel_limit ? {16'h0000, limit_sh_r} :
    sel_release ? {16'h0000, release_sh_r} : 32'h00000000;

  wire prm_hit = wr_done && (sel_hold || sel_mode || sel_limit || sel_release);
  wire [1:0] prm_sel_nxt = sel_hold ? ride_through_pkg::PRM_HOLD :
    sel_mode ? ride_through_pkg::PRM_MODE :
    sel_limit ? ride_through_pkg::PRM_LIMIT : ride_through_pkg::PRM_RELEASE;
  wire ctrl_wr = wr_done && sel_ctrl;

  // Events; a new event beats a same-cycle write-one clear
  wire [IW-1:0] ev = {ready_d_r && !link.servo_ready, warn_d_r && !link.uv_warning,
    !warn_d_r && link.uv_warning};
  wire [IW-1:0] clr = (wr_done && sel_stat) ? pwdata[IW-1:0] : '0;
  wire [IW-1:0] stat_nxt = ev | (int_stat_r & ~clr);
  wire [IW-1:0] mask_nxt = (wr_done && sel_mask) ? pwdata[IW-1:0] : int_mask_r;

  // limit when warning seen in host mode
  wire host_lim_nxt = mode_act_r == ride_through_pkg::UV_HOST && link.uv_warning;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= first_acc;
      pslverr <= first_acc && !mapped;
      if (first_acc) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      on_r <= 1'b0;
      off_r <= 1'b0;
      restart_r <= 1'b0;
      prm_wr_r <= 1'b0;
      prm_sel_r <= ride_through_pkg::PRM_HOLD;
      prm_data_r <= 16'h0000;
      hold_sh_r <= {6'h00, ride_through_pkg::HOLD_RST};
      mode_sh_r <= 16'h0000;
      limit_sh_r <= {9'h000, ride_through_pkg::LIMIT_RST};
      release_sh_r <= {6'h00, ride_through_pkg::RELEASE_RST};
      mode_act_r <= ride_through_pkg::UV_OFF;
    end else begin
      on_r <= ctrl_wr && pwdata[ride_through_pkg::CTRL_ON_BIT];
      off_r <= ctrl_wr && pwdata[ride_through_pkg::CTRL_OFF_BIT];
      restart_r <= ctrl_wr && pwdata[ride_through_pkg::CTRL_RESTART_BIT];
      prm_wr_r <= prm_hit;
      if (prm_hit) begin
        prm_sel_r <= prm_sel_nxt;
        prm_data_r <= pwdata[15:0];
      end
      if (wr_done && sel_hold) begin
        hold_sh_r <= pwdata[15:0];
      end
      if (wr_done && sel_mode) begin
        mode_sh_r <= pwdata[15:0];
      end
      if (wr_done && sel_limit) begin
        limit_sh_r <= pwdata[15:0];
      end
      if (wr_done && sel_release) begin
        release_sh_r <= pwdata[15:0];
      end
      // Track the mode the drive will adopt at restart
      if (ctrl_wr && pwdata[ride_through_pkg::CTRL_RESTART_BIT] &&
          mode_sh_r <= 16'(ride_through_pkg::UV_INTERNAL)) begin
        mode_act_r <= mode_sh_r[1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      int_stat_r <= '0;
      int_mask_r <= ride_through_pkg::INT_MASK_RST;
      irq <= 1'b0;
      warn_d_r <= 1'b0;
      ready_d_r <= 1'b0;
      host_torque_limit <= 1'b0;
    end else begin
      int_stat_r <= stat_nxt;
      int_mask_r <= mask_nxt;
      irq <= |(stat_nxt & mask_nxt);
      warn_d_r <= link.uv_warning;
      ready_d_r <= link.servo_ready;
      host_torque_limit <= host_lim_nxt;
    end
  end

  assign link.servo_on_cmd = on_r;
  assign link.servo_off_cmd = off_r;
  assign link.restart_cmd = restart_r;
  assign link.prm_wr = prm_wr_r;
  assign link.prm_sel = prm_sel_r;
  assign link.prm_data = prm_data_r;
endmodule
`default_nettype wire

// file: tb/ride_through_props.sv
// Concurrent checks across the link joining the two ride-through ends
`timescale 1ns/1ps
`default_nettype none
module ride_through_props #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic servo_off_cmd,
  input wire logic restart_cmd,
  input wire logic prm_wr,
  input wire logic [1:0] prm_sel,
  input wire logic [15:0] prm_data,
  input wire logic servo_ready,
  input wire logic uv_warning,
  input wire logic main_supply_ok,
  input wire logic ctrl_supply_ok,
  input wire logic uv_alarm,
  input wire logic motor_power_on,
  input wire logic [6:0] torque_limit_pct,
  input wire logic torque_limit_active,
  input wire logic host_torque_limit
);
  logic [15:0] hold_r, lim_r, rel_r;
  logic [1:0] pend_r, mode_r;
  int dip_r;
  int hold_cyc;
  wire logic [15:0] hold_nxt = (prm_data > 16'h03E8) ? 16'h03E8 :
                               ((prm_data < 16'h0014) ? 16'h0014 : prm_data);
  wire logic [15:0] lim_nxt = (prm_data > 16'h0064) ? 16'h0064 : prm_data;
  assign hold_cyc = (int'(hold_r) + 1) * TICK_CYCLES;
  // Shadow of the drive settings; hold and limit clamped the same way, release unclamped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= 16'h0014;
      lim_r <= 16'h0032;
      rel_r <= 16'h0064;
      pend_r <= 2'h0;
      mode_r <= 2'h0;
      dip_r <= 0;
    end else begin
      dip_r <= main_supply_ok ? 0 : dip_r + 1;
      if (restart_cmd) begin
        mode_r <= pend_r;
      end
      if (prm_wr && prm_sel == ride_through_pkg::PRM_HOLD) begin
        hold_r <= hold_nxt;
      end
      if (prm_wr && prm_sel == ride_through_pkg::PRM_MODE && prm_data <= 16'h0002) begin
        pend_r <= prm_data[1:0];
      end
      if (prm_wr && prm_sel == ride_through_pkg::PRM_LIMIT) begin
        lim_r <= lim_nxt;
      end
      if (prm_wr && prm_sel == ride_through_pkg::PRM_RELEASE) begin
        rel_r <= prm_data;
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  off_cuts_power_a: assert property (
    servo_off_cmd |=> !motor_power_on)
    else $error("motor power stayed on after servo off");
  hold_keeps_power_a: assert property (
    $fell(motor_power_on) && dip_r > 0 && !uv_alarm && ctrl_supply_ok && !$past(servo_off_cmd)
    |-> dip_r >= hold_cyc)
    else $error("motor power cut before hold time");
  hold_cuts_power_a: assert property (
    dip_r == hold_cyc + 10 |-> !motor_power_on && !servo_ready)
    else $error("motor power or ready kept past hold time");
  alarm_cut_a: assert property (
    (!main_supply_ok && uv_alarm) [*7] |-> !motor_power_on)
    else $error("undervoltage alarm in dip did not cut power");
  ctrl_loss_a: assert property (
    (!ctrl_supply_ok) [*7] |-> !motor_power_on && !servo_ready)
    else $error("control supply loss did not power down");
  mode_off_quiet_a: assert property (
    mode_r == 2'h0 && $past(mode_r) == 2'h0 |-> !uv_warning)
    else $error("warning raised with detection off");
  clamp_on_warn_a: assert property (
    $rose(uv_warning) && mode_r == 2'h2
    |-> ##[0:2] (torque_limit_pct == lim_r[6:0] && torque_limit_active))
    else $error("internal limit not applied on warning");
  release_hold_a: assert property (
    $fell(uv_warning) && mode_r == 2'h2 && rel_r != 16'h0000
    |=> (torque_limit_pct == lim_r[6:0]) [*3])
    else $error("limit dropped before release time");
  host_lim_on_a: assert property (
    $rose(uv_warning) && mode_r == 2'h1 |-> ##[0:2] host_torque_limit)
    else $error("host did not limit torque on warning");
  host_lim_off_a: assert property (
    $fell(host_torque_limit) |-> !$past(uv_warning))
    else $error("host lifted limit while warning stood");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Bench joining host and drive ends, driving APB and supply inputs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic main_supply_ok = 1'b1;
  logic ctrl_supply_ok = 1'b1;
  logic dc_bus_low = 1'b0;
  logic uv_alarm = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, irq, host_torque_limit;
  wire logic motor_power_on, drv_ready, torque_limit_active;
  wire logic [6:0] torque_limit_pct;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] q;
  logic e;
  always #5 core_clk = ~core_clk;
  ride_through_if ride_through_if_i ();
  ride_through_dev #(.TICK_CYCLES(10)) ride_through_dev_i (.core_clk(core_clk), .nrst(nrst),
    .link(ride_through_if_i), .main_supply_ok(main_supply_ok), .ctrl_supply_ok(ctrl_supply_ok),
    .dc_bus_low(dc_bus_low), .uv_alarm(uv_alarm), .motor_power_on(motor_power_on),
    .servo_ready(drv_ready), .torque_limit_active(torque_limit_active),
    .torque_limit_pct(torque_limit_pct));
  ride_through_host ride_through_host_i (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .host_torque_limit(host_torque_limit),
    .link(ride_through_if_i));
  ride_through_props #(.TICK_CYCLES(10)) ride_through_props_i (.core_clk(core_clk),
    .nrst(nrst), .servo_off_cmd(ride_through_if_i.servo_off_cmd),
    .restart_cmd(ride_through_if_i.restart_cmd), .prm_wr(ride_through_if_i.prm_wr),
    .prm_sel(ride_through_if_i.prm_sel), .prm_data(ride_through_if_i.prm_data),
    .servo_ready(ride_through_if_i.servo_ready), .uv_warning(ride_through_if_i.uv_warning),
    .main_supply_ok(main_supply_ok), .ctrl_supply_ok(ctrl_supply_ok), .uv_alarm(uv_alarm),
    .motor_power_on(motor_power_on), .torque_limit_pct(torque_limit_pct),
    .torque_limit_active(torque_limit_active), .host_torque_limit(host_torque_limit));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h00000000);
    chk(q & m, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    #300000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    cyc(10);
    chk(32'({irq, torque_limit_pct}), 32'h00000064);
    rdc(ride_through_pkg::OFS_STATUS, 32'h00000001, 32'h0000000F);
    apb(1'b0, 8'h40, 32'h00000000);
    chk(32'(e), 32'h00000001);
    chk(q, 32'h00000000);
    apb(1'b1, ride_through_pkg::OFS_HOLD, 32'h00000005);
    rdc(ride_through_pkg::OFS_HOLD, 32'h00000005, 32'hFFFFFFFF);
    apb(1'b1, ride_through_pkg::OFS_INT_MASK, 32'h00000007);
    apb(1'b1, ride_through_pkg::OFS_CTRL, 32'h00000001);
    cyc(5);
    rdc(ride_through_pkg::OFS_STATUS, 32'h00000005, 32'h00000007);
    // Short dip rides through, long dip cuts at the clamped 20 ms hold
    main_supply_ok <= 1'b0;
    cyc(150);
    chk(32'(motor_power_on), 32'h00000001);
    main_supply_ok <= 1'b1;
    cyc(20);
    main_supply_ok <= 1'b0;
    cyc(190);
    chk(32'({motor_power_on, irq}), 32'h00000002);
    cyc(40);
    chk(32'({motor_power_on, drv_ready, irq}), 32'h00000001);
    rdc(ride_through_pkg::OFS_INT_STAT, 32'h00000004, 32'h00000004);
    apb(1'b1, ride_through_pkg::OFS_INT_MASK, 32'h00000003);
    cyc(2);
    chk(32'(irq), 32'h00000000);
    apb(1'b1, ride_through_pkg::OFS_INT_STAT, 32'h00000004);
    apb(1'b1, ride_through_pkg::OFS_INT_MASK, 32'h00000007);
    main_supply_ok <= 1'b1;
    cyc(10);
    chk(32'({motor_power_on, drv_ready, irq}), 32'h00000006);
    main_supply_ok <= 1'b0;
    uv_alarm <= 1'b1;
    cyc(10);
    chk(32'(motor_power_on), 32'h00000000);
    main_supply_ok <= 1'b1;
    uv_alarm <= 1'b0;
    cyc(10);
    chk(32'(motor_power_on), 32'h00000001);
    apb(1'b1, ride_through_pkg::OFS_CTRL, 32'h00000002);
    cyc(3);
    chk(32'(motor_power_on), 32'h00000000);
    ctrl_supply_ok <= 1'b0;
    apb(1'b1, ride_through_pkg::OFS_CTRL, 32'h00000001);
    cyc(10);
    chk(32'(motor_power_on), 32'h00000000);
    ctrl_supply_ok <= 1'b1;
    cyc(10);
    chk(32'(motor_power_on), 32'h00000000);
    apb(1'b1, ride_through_pkg::OFS_CTRL, 32'h00000001);
    cyc(3);
    chk(32'(motor_power_on), 32'h00000001);
    apb(1'b1, ride_through_pkg::OFS_INT_STAT, 32'h00000007);
    // Mode write waits for restart; the illegal code is dropped
    apb(1'b1, ride_through_pkg::OFS_MODE, 32'h00000003);
    apb(1'b1, ride_through_pkg::OFS_MODE, 32'h00000001);
    dc_bus_low <= 1'b1;
    cyc(10);
    chk(32'(ride_through_if_i.uv_warning), 32'h00000000);
    dc_bus_low <= 1'b0;
    apb(1'b1, ride_through_pkg::OFS_CTRL, 32'h00000004);
    cyc(10);
    dc_bus_low <= 1'b1;
    cyc(10);
    chk(32'({ride_through_if_i.uv_warning, host_torque_limit, torque_limit_pct}),
        32'h000001E4);
    dc_bus_low <= 1'b0;
    cyc(10);
    chk(32'(host_torque_limit), 32'h00000000);
    rdc(ride_through_pkg::OFS_INT_STAT, 32'h00000003, 32'h00000003);
    apb(1'b1, ride_through_pkg::OFS_INT_STAT, 32'h00000007);
    cyc(2);
    chk(32'(irq), 32'h00000000);
    apb(1'b1, ride_through_pkg::OFS_HOLD, 32'h000003E8);
    apb(1'b1, ride_through_pkg::OFS_MODE, 32'h00000002);
    apb(1'b1, ride_through_pkg::OFS_LIMIT, 32'h0000001E);
    apb(1'b1, ride_through_pkg::OFS_RELEASE, 32'h00000005);
    apb(1'b1, ride_through_pkg::OFS_CTRL, 32'h00000004);
    cyc(10);
    dc_bus_low <= 1'b1;
    cyc(10);
    chk(32'({torque_limit_active, host_torque_limit, torque_limit_pct}), 32'h0000011E);
    dc_bus_low <= 1'b0;
    cyc(30);
    chk(32'(torque_limit_pct), 32'h0000001E);
    cyc(50);
    chk(32'({torque_limit_active, torque_limit_pct}), 32'h00000064);
    apb(1'b1, ride_through_pkg::OFS_MODE, 32'h00000000);
    apb(1'b1, ride_through_pkg::OFS_CTRL, 32'h00000004);
    cyc(5);
    dc_bus_low <= 1'b1;
    cyc(10);
    chk(32'({ride_through_if_i.uv_warning, torque_limit_pct}), 32'h00000064);
    complete_run();
  end
endmodule
`default_nettype wire
